// >>> logic/enhanced_capture_compare_pwm.sv
// capture/compare/enhanced pwm unit with avalon-mm register slave
`timescale 1ns/10ps
// Function
// - outside pwm modes only output a serves capture/compare; b, c, d stay port pins
// - pwm config 00 modulates a only; b, c, d are port pins
// - config 01 forward: d modulated, a active, b and c inactive
// - config 10 half-bridge: a and b complementary with dead-band
// - config 11 reverse: b modulated, c active, a and d inactive
// - control bits 5:4 give duty bits 1:0, only in pwm
// - mode 0000 switches off and resets state; 0001 does nothing
// - mode 0010 toggles the compare pin on each timer1 match
// - capture on falling, rising, 4th or 16th rising edge; 0011 also captures
// - modes 1000/1001 preset pin low/high, drive opposite on match, set flag
// - mode 1010 only sets the event flag on match
// - mode 1011 clears timer1 and sets flag on match
// - pwm mode low bit inverts b and d, next bit inverts a and c
// - timer1 serves capture/compare, timer2 serves pwm
// - output config, polarity and duty are buffered and take effect at the timer2 wrap
// - dead-band setting loads at every duty match while pwm runs and at every period wrap
// - enhanced pwm outputs lag by one instruction cycle
// - at period wrap clear count, set output unless duty zero, latch duty
// - duty writes any time, copied at period end; active buffer read-only in pwm
// - output clears when buffered duty equals count extended by two bits
// - duty beyond the period keeps the output set all period
// - period is four tosc times period value plus one times prescale
// - half-bridge delays each rising edge by the dead-band count
module enhanced_capture_compare_pwm #(
	parameter int DB_W = 7
) (
	input  wire logic                         clk_sys_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         ce_i,
	input  wire logic [eccp_pkg::ADDR_W-1:0]  avs_address_i,
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [eccp_pkg::DATA_W-1:0]  avs_writedata_i,
	input  wire logic [3:0]                   avs_byteenable_i,
	output logic      [eccp_pkg::DATA_W-1:0]  avs_readdata_o,
	output logic                              avs_waitrequest_o,
	input  wire logic                         capture_in_i,
	output logic      [3:0]                   bridge_out_o,
	output logic      [3:0]                   bridge_oe_o
);
	eccp_pkg::bus_state_t  bus_state_reg;
	eccp_pkg::ctrl_t       ctrl_reg;
	eccp_pkg::ctrl_t       cfg_buf_reg;
	eccp_pkg::timebase_t   tb;
	logic [7:0]            duty_wr_reg;
	logic [7:0]            active_reg;
	logic [1:0]            duty_lo_latch_reg;
	logic [7:0]            period_reg;
	logic [3:0]            timers_reg;
	logic [15:0]           t1_reg;
	logic [DB_W-1:0]       db_set_reg;
	logic [DB_W-1:0]       db_buf_reg;
	logic                  flag_reg;
	logic                  cmp_pin_reg;
	logic                  pwm_run_reg;
	logic                  pwm_raw_reg;
	logic [3:0]            lag_reg;
	logic                  cap_meta_reg;
	logic                  cap_sync_reg;
	logic                  cap_prev_reg;
	logic [3:0]            cap_div_reg;
	logic [31:0]           rd_mux;
	logic                  wr_fire;
	logic                  wr_lane0;
	logic                  ctrl_wr;
	logic                  is_pwm;
	logic                  is_capture;
	logic                  is_compare;
	logic                  mode_off;
	logic                  cmp_match;
	logic                  cap_rise;
	logic                  cap_fall;
	logic                  cap_ev;
	logic                  duty_match;
	logic [9:0]            duty_next;
	logic                  pwm_lag;
	logic [1:0]            db_in;
	logic [1:0]            db_out;
	logic [3:0]            out_next;
	logic [3:0]            oe_next;

	assign wr_fire    = ce_i && avs_write_i && (bus_state_reg == eccp_pkg::BUS_ACK);
	assign wr_lane0   = wr_fire && avs_byteenable_i[0];
	assign ctrl_wr    = wr_lane0 && (avs_address_i == eccp_pkg::OFF_CTRL);
	assign mode_off   = (ctrl_reg.mode == eccp_pkg::MODE_OFF);
	assign is_pwm     = (ctrl_reg.mode[3:2] == 2'b11);
	assign is_capture = (ctrl_reg.mode[3:2] == 2'b01) || (ctrl_reg.mode == eccp_pkg::MODE_CAP_ANY);
	assign is_compare = (ctrl_reg.mode == eccp_pkg::MODE_CMP_TGL) || (ctrl_reg.mode[3:2] == 2'b10);
	assign duty_next  = {duty_wr_reg, ctrl_reg.duty_low};
	assign duty_match = ({active_reg, duty_lo_latch_reg} == {tb.count, tb.fine});
	assign cmp_match  = ce_i && is_compare && timers_reg[eccp_pkg::TC_T1_ON_BIT]
		&& tb.inst_tick && (t1_reg == {active_reg, duty_wr_reg});
	assign pwm_lag    = lag_reg[3];

	// bus: one wait cycle, then waitrequest low for the completing edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_state_reg     <= eccp_pkg::BUS_IDLE;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end else if (ce_i) begin
			unique case (bus_state_reg)
				eccp_pkg::BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_state_reg     <= eccp_pkg::BUS_ACK;
						avs_waitrequest_o <= 1'b0;
						avs_readdata_o    <= avs_read_i ? rd_mux : 32'h0000_0000;
					end
				end
				eccp_pkg::BUS_ACK: begin
					bus_state_reg     <= eccp_pkg::BUS_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			eccp_pkg::OFF_CTRL:     rd_mux[7:0] = ctrl_reg;
			eccp_pkg::OFF_DUTY_WR:  rd_mux[7:0] = duty_wr_reg;
			eccp_pkg::OFF_ACTIVE:   rd_mux[7:0] = active_reg;
			eccp_pkg::OFF_PERIOD:   rd_mux[7:0] = period_reg;
			eccp_pkg::OFF_TIMERS:   rd_mux[3:0] = timers_reg;
			eccp_pkg::OFF_T1:       rd_mux[15:0] = t1_reg;
			eccp_pkg::OFF_DEADBAND: rd_mux[DB_W-1:0] = db_set_reg;
			eccp_pkg::OFF_STATUS: begin
				rd_mux[eccp_pkg::ST_FLAG_BIT]                     = flag_reg;
				rd_mux[eccp_pkg::ST_RUN_BIT]                      = pwm_run_reg;
				rd_mux[eccp_pkg::ST_T2_LSB +: 8]                  = tb.count;
			end
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg   <= eccp_pkg::RST_CTRL;
			period_reg <= eccp_pkg::RST_PERIOD;
			timers_reg <= eccp_pkg::RST_TIMERS;
			db_set_reg <= eccp_pkg::RST_DEADBAND;
		end else if (wr_lane0) begin
			case (avs_address_i)
				eccp_pkg::OFF_CTRL:     ctrl_reg   <= avs_writedata_i[7:0];
				eccp_pkg::OFF_PERIOD:   period_reg <= avs_writedata_i[7:0];
				eccp_pkg::OFF_TIMERS:   timers_reg <= avs_writedata_i[3:0];
				eccp_pkg::OFF_DEADBAND: db_set_reg <= avs_writedata_i[DB_W-1:0];
				default: ;
			endcase
		end
	end

	// capture input crosses from the pin: two flops before any edge logic
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_meta_reg <= 1'b0;
			cap_sync_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
		end else if (ce_i) begin
			cap_meta_reg <= capture_in_i;
			cap_sync_reg <= cap_meta_reg;
			cap_prev_reg <= cap_sync_reg;
		end
	end

	assign cap_rise = cap_sync_reg && !cap_prev_reg;
	assign cap_fall = !cap_sync_reg && cap_prev_reg;

	always_comb begin
		unique case (ctrl_reg.mode)
			eccp_pkg::MODE_CAP_ANY:  cap_ev = cap_rise || cap_fall;
			eccp_pkg::MODE_CAP_FALL: cap_ev = cap_fall;
			eccp_pkg::MODE_CAP_RISE: cap_ev = cap_rise;
			eccp_pkg::MODE_CAP_4TH:  cap_ev = cap_rise && (cap_div_reg[1:0] == 2'h3);
			eccp_pkg::MODE_CAP_16TH: cap_ev = cap_rise && (cap_div_reg == 4'hf);
			default:                 cap_ev = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_div_reg <= 4'h0;
		end else if (ce_i) begin
			if (!is_capture) begin
				cap_div_reg <= 4'h0;
			end else if (cap_rise) begin
				cap_div_reg <= cap_div_reg + 4'h1;
			end
		end
	end

	// timer1 time base of capture/compare; special event wins over increment
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			t1_reg <= 16'h0000;
		end else if (ce_i) begin
			if (cmp_match && ctrl_reg.mode == eccp_pkg::MODE_CMP_SPEC) begin
				t1_reg <= 16'h0000;
			end else if (wr_fire && avs_address_i == eccp_pkg::OFF_T1) begin
				if (avs_byteenable_i[0]) t1_reg[7:0] <= avs_writedata_i[7:0];
				if (avs_byteenable_i[1]) t1_reg[15:8] <= avs_writedata_i[15:8];
			end else if (timers_reg[eccp_pkg::TC_T1_ON_BIT] && tb.inst_tick) begin
				t1_reg <= t1_reg + 16'h0001;
			end
		end
	end

	// duty write byte and active buffer share capture and pwm roles; low latch is pwm only
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_wr_reg       <= eccp_pkg::RST_DUTY;
			active_reg        <= eccp_pkg::RST_DUTY;
			duty_lo_latch_reg <= 2'h0;
		end else if (ce_i) begin
			if (cap_ev) begin
				{active_reg, duty_wr_reg} <= t1_reg;
			end else begin
				if (wr_lane0 && avs_address_i == eccp_pkg::OFF_DUTY_WR) begin
					duty_wr_reg <= avs_writedata_i[7:0];
				end
				if (mode_off) begin
					duty_lo_latch_reg <= 2'h0;
				end else if (tb.period_tick && is_pwm) begin
					{active_reg, duty_lo_latch_reg} <= duty_next;
				end else if (wr_lane0 && avs_address_i == eccp_pkg::OFF_ACTIVE && !is_pwm) begin
					active_reg <= avs_writedata_i[7:0];
				end
			end
		end
	end

	// hardware set wins over software clear
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_reg <= 1'b0;
		end else if (ce_i) begin
			if (cap_ev || cmp_match) begin
				flag_reg <= 1'b1;
			end else if (wr_lane0 && avs_address_i == eccp_pkg::OFF_STATUS
				&& avs_writedata_i[eccp_pkg::ST_FLAG_BIT]) begin
				flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_pin_reg <= 1'b0;
		end else if (ctrl_wr) begin
			case (avs_writedata_i[3:0])
				eccp_pkg::MODE_OFF:     cmp_pin_reg <= 1'b0;
				eccp_pkg::MODE_CMP_SET: cmp_pin_reg <= 1'b0;
				eccp_pkg::MODE_CMP_CLR: cmp_pin_reg <= 1'b1;
				default: ;
			endcase
		end else if (cmp_match) begin
			case (ctrl_reg.mode)
				eccp_pkg::MODE_CMP_TGL: cmp_pin_reg <= !cmp_pin_reg;
				eccp_pkg::MODE_CMP_SET: cmp_pin_reg <= 1'b1;
				eccp_pkg::MODE_CMP_CLR: cmp_pin_reg <= 1'b0;
				default: ;
			endcase
		end
	end

	period_timebase u_timebase (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.ce_i       (ce_i),
		.run_i      (timers_reg[eccp_pkg::TC_T2_ON_BIT]),
		.prescale_i (timers_reg[eccp_pkg::TC_PRE_LSB +: 2]),
		.period_i   (period_reg),
		.tb_o       (tb)
	);

	// settings held until the wrap so no output glitches mid-period
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_run_reg <= 1'b0;
			pwm_raw_reg <= 1'b0;
			cfg_buf_reg <= eccp_pkg::RST_CTRL;
		end else if (ce_i) begin
			if (mode_off) begin
				pwm_run_reg <= 1'b0;
				pwm_raw_reg <= 1'b0;
				cfg_buf_reg <= eccp_pkg::RST_CTRL;
			end else if (tb.period_tick) begin
				pwm_run_reg <= is_pwm;
				cfg_buf_reg <= ctrl_reg;
				pwm_raw_reg <= is_pwm && (duty_next != 10'h000);
			end else if (!is_pwm) begin
				pwm_run_reg <= 1'b0;
				pwm_raw_reg <= 1'b0;
			end else if (duty_match) begin
				pwm_raw_reg <= 1'b0;
			end
		end
	end

	// one instruction cycle of lag from the buffering
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lag_reg <= 4'h0;
		end else if (ce_i) begin
			lag_reg <= {lag_reg[2:0], pwm_raw_reg};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			db_buf_reg <= eccp_pkg::RST_DEADBAND;
		end else if (ce_i && (tb.period_tick || (duty_match && pwm_run_reg))) begin
			db_buf_reg <= db_set_reg;
		end
	end

	assign db_in[0] = pwm_run_reg && (cfg_buf_reg.out_cfg == eccp_pkg::CFG_HALF) && pwm_lag;
	assign db_in[1] = pwm_run_reg && (cfg_buf_reg.out_cfg == eccp_pkg::CFG_HALF) && !pwm_lag;

	for (genvar i = 0; i < 2; i++) begin : g_leg
		deadband_delay #(.CNT_W(DB_W)) u_deadband (
			.clk_sys_i   (clk_sys_i),
			.rst_n_i     (rst_n_i),
			.ce_i        (ce_i),
			.inst_tick_i (tb.inst_tick),
			.level_i     (db_in[i]),
			.delay_i     (db_buf_reg),
			.level_o     (db_out[i])
		);
	end

	always_comb begin
		out_next = 4'h0;
		oe_next  = 4'h0;
		if (pwm_run_reg) begin
			unique case (cfg_buf_reg.out_cfg)
				eccp_pkg::CFG_SINGLE: begin
					oe_next  = 4'h1;
					out_next = {3'h0, pwm_lag};
				end
				eccp_pkg::CFG_FWD: begin
					oe_next  = 4'hf;
					out_next = {pwm_lag, 2'h0, 1'b1};
				end
				eccp_pkg::CFG_HALF: begin
					oe_next  = 4'h3;
					out_next = {2'h0, db_out[1], db_out[0]};
				end
				eccp_pkg::CFG_REV: begin
					oe_next  = 4'hf;
					out_next = {1'b0, 1'b1, pwm_lag, 1'b0};
				end
			endcase
			out_next = out_next ^ (oe_next & {cfg_buf_reg.mode[0], cfg_buf_reg.mode[1],
				cfg_buf_reg.mode[0], cfg_buf_reg.mode[1]});
		end else begin
			out_next[0] = cmp_pin_reg;
			oe_next[0]  = (ctrl_reg.mode == eccp_pkg::MODE_CMP_TGL)
				|| (ctrl_reg.mode == eccp_pkg::MODE_CMP_SET)
				|| (ctrl_reg.mode == eccp_pkg::MODE_CMP_CLR);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bridge_out_o <= 4'h0;
			bridge_oe_o  <= 4'h0;
		end else if (ce_i) begin
			bridge_out_o <= out_next;
			bridge_oe_o  <= oe_next;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_ce4;
		ce_i [*4];
	endsequence
	sequence s_wrap_load;
		ce_i && tb.period_tick && is_pwm && !mode_off && !cap_ev;
	endsequence

	AST_NONPWM_PORTS: assert property (ce_i && !pwm_run_reg |=> bridge_oe_o[3:1] == 3'h0)
		else $error("b/c/d driven outside pwm");
	AST_SINGLE: assert property (ce_i && pwm_run_reg && cfg_buf_reg.out_cfg == 2'h0
		|=> bridge_oe_o == 4'h1)
		else $error("single output drives wrong pins");
	AST_FORWARD: assert property (ce_i && pwm_run_reg && cfg_buf_reg.out_cfg == 2'h1
		|=> bridge_oe_o == 4'hf && bridge_out_o[0] == !$past(cfg_buf_reg.mode[1])
		&& bridge_out_o[1] == $past(cfg_buf_reg.mode[0]))
		else $error("forward bridge levels wrong");
	AST_HALF: assert property (ce_i && pwm_run_reg && cfg_buf_reg.out_cfg == 2'h2
		|=> bridge_oe_o == 4'h3)
		else $error("half bridge drives wrong pins");
	AST_REVERSE: assert property (ce_i && pwm_run_reg && cfg_buf_reg.out_cfg == 2'h3
		|=> bridge_oe_o == 4'hf && bridge_out_o[2] == !$past(cfg_buf_reg.mode[1])
		&& bridge_out_o[0] == $past(cfg_buf_reg.mode[1]))
		else $error("reverse bridge levels wrong");
	AST_OFF: assert property (ce_i && mode_off |=> !pwm_run_reg && !pwm_raw_reg)
		else $error("off mode left pwm running");
	AST_TOGGLE: assert property (cmp_match && ctrl_reg.mode == 4'h2 && !ctrl_wr
		|=> cmp_pin_reg == !$past(cmp_pin_reg))
		else $error("compare toggle missed");
	AST_SPECIAL: assert property (ce_i && cmp_match && ctrl_reg.mode == 4'hb
		|=> t1_reg == 16'h0000 && flag_reg)
		else $error("special event did not clear timer1");
	AST_LATCH: assert property (s_wrap_load |=> {active_reg, duty_lo_latch_reg} == $past(duty_next)
		&& pwm_raw_reg == ($past(duty_next) != 10'h000))
		else $error("period wrap did not latch duty");
	AST_READONLY: assert property (wr_lane0 && avs_address_i == 5'h08 && is_pwm
		&& !tb.period_tick && !cap_ev |=> active_reg == $past(active_reg))
		else $error("active duty written in pwm");
	AST_CLEAR: assert property (ce_i && is_pwm && !mode_off && duty_match && !tb.period_tick
		|=> !pwm_raw_reg)
		else $error("duty match did not clear output");
	AST_LAG: assert property (s_ce4 |=> lag_reg[3] == $past(pwm_raw_reg, 4))
		else $error("pwm lag not one instruction cycle");
endmodule

// >>> logic/eccp_pkg.sv
// shared constants, register map and carrier types of the capture/compare/pwm unit
package eccp_pkg;
	localparam int          DATA_W        = 32;
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  OFF_CTRL      = 5'h00;
	localparam logic [4:0]  OFF_DUTY_WR   = 5'h04;
	localparam logic [4:0]  OFF_ACTIVE    = 5'h08;
	localparam logic [4:0]  OFF_PERIOD    = 5'h0c;
	localparam logic [4:0]  OFF_TIMERS    = 5'h10;
	localparam logic [4:0]  OFF_T1        = 5'h14;
	localparam logic [4:0]  OFF_DEADBAND  = 5'h18;
	localparam logic [4:0]  OFF_STATUS    = 5'h1c;
	localparam logic [7:0]  RST_CTRL      = 8'h00;
	localparam logic [7:0]  RST_DUTY      = 8'h00;
	localparam logic [7:0]  RST_PERIOD    = 8'hff;
	localparam logic [3:0]  RST_TIMERS    = 4'h0;
	localparam logic [6:0]  RST_DEADBAND  = 7'h00;
	localparam int          TC_T1_ON_BIT  = 0;
	localparam int          TC_T2_ON_BIT  = 1;
	localparam int          TC_PRE_LSB    = 2;
	localparam int          ST_FLAG_BIT   = 0;
	localparam int          ST_RUN_BIT    = 1;
	localparam int          ST_T2_LSB     = 8;
	localparam logic [3:0]  MODE_OFF      = 4'h0;
	localparam logic [3:0]  MODE_CMP_TGL  = 4'h2;
	localparam logic [3:0]  MODE_CAP_ANY  = 4'h3;
	localparam logic [3:0]  MODE_CAP_FALL = 4'h4;
	localparam logic [3:0]  MODE_CAP_RISE = 4'h5;
	localparam logic [3:0]  MODE_CAP_4TH  = 4'h6;
	localparam logic [3:0]  MODE_CAP_16TH = 4'h7;
	localparam logic [3:0]  MODE_CMP_SET  = 4'h8;
	localparam logic [3:0]  MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0]  MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0]  MODE_CMP_SPEC = 4'hb;
	localparam logic [1:0]  CFG_SINGLE    = 2'h0;
	localparam logic [1:0]  CFG_FWD       = 2'h1;
	localparam logic [1:0]  CFG_HALF      = 2'h2;
	localparam logic [1:0]  CFG_REV       = 2'h3;
	localparam logic [1:0]  PRE_1         = 2'h0;
	localparam logic [1:0]  PRE_4         = 2'h1;
	localparam int          TOSC_PER_INST = 4;
	typedef struct packed {
		logic [1:0] out_cfg;
		logic [1:0] duty_low;
		logic [3:0] mode;
	} ctrl_t;
	typedef struct packed {
		logic       inst_tick;
		logic       period_tick;
		logic [7:0] count;
		logic [1:0] fine;
	} timebase_t;
	typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// >>> logic/period_timebase.sv
// quarter-cycle phase, prescaler and period timer feeding the pwm compare
`timescale 1ns/10ps
module period_timebase (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              run_i,
	input  wire logic [1:0]        prescale_i,
	input  wire logic [7:0]        period_i,
	output eccp_pkg::timebase_t    tb_o
);
	logic [1:0] q_reg;
	logic [3:0] pre_reg;
	logic [7:0] cnt_reg;
	logic       tick_reg;
	logic       pre_wrap;
	logic       inc;

	always_comb begin
		if (prescale_i == eccp_pkg::PRE_1) begin
			pre_wrap = 1'b1;
		end else if (prescale_i == eccp_pkg::PRE_4) begin
			pre_wrap = (pre_reg[1:0] == 2'h3);
		end else begin
			pre_wrap = (pre_reg == 4'hf);
		end
	end
	assign inc = run_i && (q_reg == 2'h3) && pre_wrap;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_reg <= 2'h0;
		end else if (ce_i) begin
			q_reg <= q_reg + 2'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_reg <= 4'h0;
		end else if (ce_i) begin
			if (!run_i) begin
				pre_reg <= 4'h0;
			end else if (q_reg == 2'h3) begin
				pre_reg <= pre_wrap ? 4'h0 : pre_reg + 4'h1;
			end
		end
	end

	// period = 4 tosc * (period + 1) * prescale
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg  <= 8'h00;
			tick_reg <= 1'b0;
		end else if (ce_i) begin
			tick_reg <= inc && (cnt_reg == period_i);
			if (inc) begin
				cnt_reg <= (cnt_reg == period_i) ? 8'h00 : cnt_reg + 8'h01;
			end
		end
	end

	assign tb_o.inst_tick   = (q_reg == 2'h3);
	assign tb_o.period_tick = tick_reg;
	assign tb_o.count       = cnt_reg;
	assign tb_o.fine        = (prescale_i == eccp_pkg::PRE_1) ? q_reg :
		(prescale_i == eccp_pkg::PRE_4) ? pre_reg[1:0] : pre_reg[3:2];
endmodule

// >>> logic/deadband_delay.sv
// delays the inactive-to-active edge of one bridge leg by whole instruction cycles
`timescale 1ns/10ps
module deadband_delay #(
	parameter int CNT_W = 7
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	input  wire logic             inst_tick_i,
	input  wire logic             level_i,
	input  wire logic [CNT_W-1:0] delay_i,
	output logic                  level_o
);
	logic [CNT_W-1:0] cnt_reg;

	// falling edge passes at once, so the opposite leg never waits on this one
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
			level_o <= 1'b0;
		end else if (ce_i) begin
			if (!level_i) begin
				cnt_reg <= '0;
				level_o <= 1'b0;
			end else if (!level_o) begin
				if (cnt_reg >= delay_i) begin
					level_o <= 1'b1;
				end else if (inst_tick_i) begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
endmodule

// >>> testbench/bridge_driver_model.sv
// behavioural power-switch driver stage watching the bridge pins
`timescale 1ns/10ps
module bridge_driver_model (
	input  wire logic        clk_sys_i,
	input  wire logic        clr_i,
	input  wire logic [3:0]  out_i,
	input  wire logic [3:0]  oe_i,
	output logic      [3:0]  pin_o,
	output logic      [15:0] hi_cnt_o
);
	// undriven pins sit on the driver's pull-down, never on a stale level
	assign pin_o = out_i & oe_i;
	always_ff @(posedge clk_sys_i) begin
		if (clr_i)
			hi_cnt_o <= 16'h0000;
		else if (pin_o[0])
			hi_cnt_o <= hi_cnt_o + 16'h0001;
	end
endmodule

// >>> testbench/enhanced_capture_compare_pwm_tb_top.sv
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/10ps
module enhanced_capture_compare_pwm_tb_top;
	logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr_en = 1'b0, clr = 1'b1;
	logic        cap = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wdat = 32'h00000000, rdat, q;
	logic        wait_o;
	logic [3:0]  out_o, oe_o, pin;
	logic [15:0] hi_cnt;
	int          err_count = 0, n_tests = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	enhanced_capture_compare_pwm i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr_en), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
		.capture_in_i(cap), .bridge_out_o(out_o), .bridge_oe_o(oe_o));
	bridge_driver_model i_drv (.clk_sys_i(clk_sys_i), .clr_i(clr), .out_i(out_o), .oe_i(oe_o),
		.pin_o(pin), .hi_cnt_o(hi_cnt));
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		wr_en <= w;
		rd <= ~w;
		do @(posedge clk_sys_i); while (wait_o !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr_en <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic t_reset;
		bus(1'b0, eccp_pkg::OFF_CTRL, 0);
		chk(q, 32'h00000000);
		bus(1'b0, eccp_pkg::OFF_PERIOD, 0);
		chk(q, 32'h000000ff);
		bus(1'b0, 5'h01, 0);
		chk(q, 32'h00000000);
		$display("reset test done");
	endtask
	task automatic t_cap;
		int n;
		for (int m = 4; m <= 7; m++) begin
			n = (m == 7) ? 16 : (m == 6) ? 4 : 1;
			bus(1'b1, eccp_pkg::OFF_CTRL, 0);
			bus(1'b1, eccp_pkg::OFF_TIMERS, 0);
			bus(1'b1, eccp_pkg::OFF_T1, 32'h00001230 + m);
			bus(1'b1, eccp_pkg::OFF_CTRL, m);
			bus(1'b1, eccp_pkg::OFF_STATUS, 32'h00000001);
			for (int p = 1; p <= n; p++) begin
				if (p == n) begin
					bus(1'b0, eccp_pkg::OFF_STATUS, 0);
					chk(q[0], 1'b0);
				end
				cap <= 1'b1;
				repeat (4) @(posedge clk_sys_i);
				cap <= 1'b0;
				repeat (4) @(posedge clk_sys_i);
			end
			bus(1'b0, eccp_pkg::OFF_STATUS, 0);
			chk(q[0], 1'b1);
			bus(1'b0, eccp_pkg::OFF_ACTIVE, 0);
			chk(q, 32'h00000012);
			bus(1'b0, eccp_pkg::OFF_DUTY_WR, 0);
			chk(q, 32'h00000030 + m);
		end
		$display("capture test done");
	endtask
	task automatic t_cmp;
		logic [3:0] md [5];
		md = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, eccp_pkg::OFF_TIMERS, 0);
			bus(1'b1, eccp_pkg::OFF_T1, 0);
			bus(1'b1, eccp_pkg::OFF_DUTY_WR, 32'h00000010);
			bus(1'b1, eccp_pkg::OFF_ACTIVE, 0);
			bus(1'b1, eccp_pkg::OFF_STATUS, 32'h00000001);
			bus(1'b1, eccp_pkg::OFF_CTRL, md[i]);
			@(negedge clk_sys_i);
			chk({oe_o[0], out_o[0] & oe_o[0]}, {md[i] <= 4'h9, md[i] == 4'h9});
			@(posedge clk_sys_i);
			bus(1'b1, eccp_pkg::OFF_TIMERS, 32'h00000001);
			repeat (100) @(posedge clk_sys_i);
			chk(out_o[0] & oe_o[0], md[i] == 4'h8 || md[i] == 4'h2);
			bus(1'b0, eccp_pkg::OFF_STATUS, 0);
			chk(q[0], 1'b1);
			bus(1'b0, eccp_pkg::OFF_T1, 0);
			chk(q[15:0] <= 16'h0010, md[i] == 4'hb);
		end
		$display("compare test done");
	endtask
	task automatic t_map;
		logic [3:0] e, oe_t [4], out_t [4];
		oe_t = '{4'h1, 4'hf, 4'h3, 4'hf};
		out_t = '{4'h1, 4'h9, 4'h1, 4'h6};
		bus(1'b1, eccp_pkg::OFF_PERIOD, 32'h00000003);
		bus(1'b1, eccp_pkg::OFF_DUTY_WR, 32'h000000ff);
		bus(1'b1, eccp_pkg::OFF_TIMERS, 32'h00000002);
		for (int m = 12; m <= 15; m += 3)
			for (int c = 0; c < 4; c++) begin
				bus(1'b1, eccp_pkg::OFF_CTRL, {c[1:0], 2'b11, m[3:0]});
				repeat (80) @(posedge clk_sys_i);
				e = (m == 15) ? out_t[c] ^ oe_t[c] : out_t[c];
				chk(oe_o, oe_t[c]);
				chk(out_o & oe_o, e);
			end
		$display("output map test done");
	endtask
	task automatic t_duty;
		logic [9:0] d [2];
		d = '{10'h00d, 10'h000};
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, eccp_pkg::OFF_DUTY_WR, d[i][9:2]);
			bus(1'b1, eccp_pkg::OFF_CTRL, {2'b00, d[i][1:0], 4'hc});
			repeat (40) @(posedge clk_sys_i);
			clr <= 1'b0;
			repeat (160) @(posedge clk_sys_i);
			clr <= 1'b1;
			@(negedge clk_sys_i);
			chk(hi_cnt, 10 * d[i]);
			@(posedge clk_sys_i);
			bus(1'b1, eccp_pkg::OFF_ACTIVE, 32'h00000055);
			bus(1'b0, eccp_pkg::OFF_ACTIVE, 0);
			chk(q, d[i][9:2]);
		end
		$display("duty test done");
	endtask
	task automatic t_off;
		for (int m = 1; m >= 0; m--) begin
			bus(1'b1, eccp_pkg::OFF_CTRL, m);
			@(posedge clk_sys_i);
			@(negedge clk_sys_i);
			chk({out_o & oe_o, oe_o}, 8'h00);
			@(posedge clk_sys_i);
		end
		$display("off test done");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		t_reset();
		t_cap();
		t_cmp();
		t_map();
		t_duty();
		t_off();
		print_verdict();
	end
	// generous span: the tests need a few thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_count++;
		print_verdict();
	end
endmodule
